/* common/drive_objects_pkg.sv */
`default_nettype none

package drive_objects_pkg;

    // Object indices of the dictionary entries held here
    localparam logic [15:0] IDX_POS_UNIT   = 16'h60a8;
    localparam logic [15:0] IDX_VEL_UNIT   = 16'h60a9;
    localparam logic [15:0] IDX_POS_OFFSET = 16'h60b0;
    localparam logic [15:0] IDX_SPD_OFFSET = 16'h60b1;
    localparam logic [15:0] IDX_TRQ_OFFSET = 16'h60b2;
    localparam logic [15:0] IDX_IP_RECORD  = 16'h60c1;
    localparam logic [15:0] IDX_IP_PERIOD  = 16'h60c2;

    // Subindices
    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_FIRST = 8'h01;
    localparam logic [7:0] SUB_SECND = 8'h02;

    // Writable bits of the unit codes; reserved bits stay zero
    localparam logic [31:0] POS_UNIT_MASK = 32'hffff0000;
    localparam logic [31:0] VEL_UNIT_MASK = 32'hffffff00;

    // Reset values
    localparam logic [31:0] POS_UNIT_RST     = 32'hff410000;
    localparam logic [31:0] VEL_UNIT_RST     = 32'h00b44700;
    localparam logic [31:0] OFFSET32_RST     = 32'h00000000;
    localparam logic [15:0] OFFSET16_RST     = 16'h0000;
    localparam logic [31:0] DEMAND_RST       = 32'h00000000;
    localparam logic [7:0]  IP_RECORD_COUNT  = 8'h01;
    localparam logic [7:0]  IP_PERIOD_COUNT  = 8'h02;
    localparam logic [7:0]  IP_PERIOD_RST    = 8'h01;
    localparam logic [7:0]  IP_EXPONENT_RST  = 8'hfd;

    // Exponent that the master is expected to use (milliseconds)
    localparam logic signed [7:0] IP_EXPONENT_MS = 8'shfd;

    // Operating modes reported by the motion core
    typedef enum logic [2:0]
    {
        MODE_OTHER,
        MODE_CSP,
        MODE_CSV,
        MODE_CST,
        MODE_CLK_DIR,
        MODE_IP
    } drive_mode_e;

    // Object dictionary access request
    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [15:0] index;
        logic [7:0]  subindex;
        logic [31:0] wdata;
    } od_req_s;

    // Set values from the motion core
    typedef struct packed
    {
        logic signed [31:0] pos;
        logic signed [31:0] spd;
        logic signed [15:0] trq;
    } setpoint_s;

    // Cycle time in microseconds from period value and power of ten
    function automatic logic [31:0] cycle_time_us(input logic [7:0] val, input logic signed [7:0] expo);
        logic [31:0] scale;
        scale = 32'h00000000;
        case (expo)
            -8'sd6:  scale = 32'h00000001;
            -8'sd5:  scale = 32'h0000000a;
            -8'sd4:  scale = 32'h00000064;
            -8'sd3:  scale = 32'h000003e8;
            -8'sd2:  scale = 32'h00002710;
            -8'sd1:  scale = 32'h000186a0;
            8'sd0:   scale = 32'h000f4240;
            default: scale = 32'h00000000;
        endcase
        return 32'({24'h000000, val} * scale);
    endfunction

endpackage

`default_nettype wire

/* rtl/drive_unit_offset_interp_objects.sv */
// How it works
// - Position unit: code 23:16, exponent 31:24.
// - Velocity unit: time, position, exponent fields.
// - Position offset added in cyclic position mode.
// - Speed offset in CSP, CSV, clock-direction.
// - Torque offset in cyclic and clock-direction modes.
// - One signed 32-bit interpolation demand position.
// - Demand position taken over at next sync.
// - Cycle time equals period times ten^exponent; zero for exponents outside -6 to 0.
`default_nettype none

module drive_unit_offset_interp_objects
    import drive_objects_pkg::*;
(
    // Clock and reset
    input  wire logic          i_sys_clk,
    input  wire logic          i_nrst,
    // Object dictionary access
    input  wire od_req_s       i_od_req,
    output logic               o_od_ack,
    output logic               o_od_err,
    output logic [31:0]        o_od_rdata,
    // Motion core
    input  wire logic          i_sync,
    input  wire drive_mode_e   i_mode,
    input  wire setpoint_s     i_set,
    output setpoint_s          o_cmd,
    output logic signed [31:0] o_ip_demand,
    output logic [31:0]        o_pos_unit,
    output logic [31:0]        o_vel_unit,
    output logic [31:0]        o_ip_cycle_us,
    output logic               o_ip_exp_bad
);

    // Stored objects
    logic [31:0]        pos_unit_reg;      // Position unit code
    logic [31:0]        vel_unit_reg;      // Velocity unit code
    logic signed [31:0] pos_off_reg;       // Position offset
    logic signed [31:0] spd_off_reg;       // Speed offset
    logic signed [15:0] trq_off_reg;       // Torque offset, tenths of a percent
    logic signed [31:0] demand_reg;        // Written demand, not yet in use
    logic [7:0]         period_reg;        // Interpolation period value
    logic signed [7:0]  expo_reg;          // Interpolation power of ten
    // Answer path
    logic               ack_reg;
    logic               err_reg;
    logic [31:0]        rdata_reg;
    // Motion outputs
    setpoint_s          cmd_reg;
    setpoint_s          cmd_next;
    logic signed [31:0] ip_demand_reg;
    logic [31:0]        cycle_reg;

    // Address decode of each object entry
    wire hit_pos_unit = (i_od_req.index == IDX_POS_UNIT) && (i_od_req.subindex == SUB_COUNT);
    wire hit_vel_unit = (i_od_req.index == IDX_VEL_UNIT) && (i_od_req.subindex == SUB_COUNT);
    wire hit_pos_off  = (i_od_req.index == IDX_POS_OFFSET) && (i_od_req.subindex == SUB_COUNT);
    wire hit_spd_off  = (i_od_req.index == IDX_SPD_OFFSET) && (i_od_req.subindex == SUB_COUNT);
    wire hit_trq_off  = (i_od_req.index == IDX_TRQ_OFFSET) && (i_od_req.subindex == SUB_COUNT);
    wire hit_rec_cnt  = (i_od_req.index == IDX_IP_RECORD) && (i_od_req.subindex == SUB_COUNT);
    wire hit_demand   = (i_od_req.index == IDX_IP_RECORD) && (i_od_req.subindex == SUB_FIRST);
    wire hit_per_cnt  = (i_od_req.index == IDX_IP_PERIOD) && (i_od_req.subindex == SUB_COUNT);
    wire hit_period   = (i_od_req.index == IDX_IP_PERIOD) && (i_od_req.subindex == SUB_FIRST);
    wire hit_expo     = (i_od_req.index == IDX_IP_PERIOD) && (i_od_req.subindex == SUB_SECND);

    // Entries that accept a write, and entries that exist at all
    wire hit_rw   = hit_pos_unit | hit_vel_unit | hit_pos_off | hit_spd_off | hit_trq_off
                  | hit_demand | hit_period | hit_expo;
    wire hit_any  = hit_rw | hit_rec_cnt | hit_per_cnt;
    wire req_any  = i_od_req.wr | i_od_req.rd;
    wire wr_ok    = i_od_req.wr & hit_rw;
    // Write to a count entry or an unknown entry, or read of an unknown one
    wire req_bad  = i_od_req.wr ? ~hit_rw : ~hit_any;

    // Read data selection; narrow entries sit in the low bits
    wire [31:0] rd_mux =
        hit_pos_unit ? pos_unit_reg :
        hit_vel_unit ? vel_unit_reg :
        hit_pos_off  ? pos_off_reg :
        hit_spd_off  ? spd_off_reg :
        hit_trq_off  ? {16'h0000, trq_off_reg} :
        hit_rec_cnt  ? {24'h000000, IP_RECORD_COUNT} :
        hit_demand   ? demand_reg :
        hit_per_cnt  ? {24'h000000, IP_PERIOD_COUNT} :
        hit_period   ? {24'h000000, period_reg} :
        hit_expo     ? {24'h000000, expo_reg} :
                       32'h00000000;

    // Offset enables per operating mode
    wire pos_off_en = (i_mode == MODE_CSP);
    wire spd_off_en = (i_mode == MODE_CSP) || (i_mode == MODE_CSV) || (i_mode == MODE_CLK_DIR);
    wire trq_off_en = spd_off_en || (i_mode == MODE_CST);

    // Corrected set values
    always_comb
    begin
        cmd_next.pos = pos_off_en ? 32'(i_set.pos + pos_off_reg) : i_set.pos;
        cmd_next.spd = spd_off_en ? 32'(i_set.spd + spd_off_reg) : i_set.spd;
        cmd_next.trq = trq_off_en ? 16'(i_set.trq + trq_off_reg) : i_set.trq;
    end

    // Unit code storage; reserved low bits never take a write
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            pos_unit_reg <= POS_UNIT_RST;
            vel_unit_reg <= VEL_UNIT_RST;
        end
        else if (wr_ok)
        begin
            if (hit_pos_unit)
            begin
                pos_unit_reg <= i_od_req.wdata & POS_UNIT_MASK;
            end
            if (hit_vel_unit)
            begin
                vel_unit_reg <= i_od_req.wdata & VEL_UNIT_MASK;
            end
        end
    end

    // Offset storage
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            pos_off_reg <= OFFSET32_RST;
            spd_off_reg <= OFFSET32_RST;
            trq_off_reg <= OFFSET16_RST;
        end
        else if (wr_ok)
        begin
            if (hit_pos_off)
                pos_off_reg <= i_od_req.wdata;
            if (hit_spd_off)
                spd_off_reg <= i_od_req.wdata;
            if (hit_trq_off)
                trq_off_reg <= i_od_req.wdata[15:0];
        end
    end

    // Interpolation entries; demand is only held here until sync
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            demand_reg <= DEMAND_RST;
            period_reg <= IP_PERIOD_RST;
            expo_reg   <= IP_EXPONENT_RST;
        end
        else if (wr_ok)
        begin
            if (hit_demand)
                demand_reg <= i_od_req.wdata;
            if (hit_period)
                period_reg <= i_od_req.wdata[7:0];
            if (hit_expo)
                expo_reg <= i_od_req.wdata[7:0];
        end
    end

    // Access answer, one cycle after the request
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ack_reg   <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= 32'h00000000;
        end
        else
        begin
            ack_reg <= req_any;
            err_reg <= req_any & req_bad;
            // Read data only refreshed on a good read
            if (i_od_req.rd && !i_od_req.wr && hit_any)
                rdata_reg <= rd_mux;
        end
    end

    // Motion path outputs
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cmd_reg       <= '0;
            ip_demand_reg <= DEMAND_RST;
            cycle_reg     <= 32'h00000000;
        end
        else
        begin
            cmd_reg   <= cmd_next;
            cycle_reg <= cycle_time_us(period_reg, expo_reg);
            // Demand becomes active only at the sync instant
            if (i_sync)
                ip_demand_reg <= demand_reg;
        end
    end

    // Output drive
    assign o_od_ack      = ack_reg;
    assign o_od_err      = err_reg;
    assign o_od_rdata    = rdata_reg;
    assign o_cmd         = cmd_reg;
    assign o_ip_demand   = ip_demand_reg;
    assign o_pos_unit    = pos_unit_reg;
    assign o_vel_unit    = vel_unit_reg;
    assign o_ip_cycle_us = cycle_reg;
    // Flags an exponent other than the millisecond base
    assign o_ip_exp_bad  = (expo_reg != IP_EXPONENT_MS);

    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    a_demand_at_sync: assert property (i_sync |=> o_ip_demand == $past(demand_reg))
        else $error("demand not taken at sync");
    a_demand_waits: assert property (!i_sync |=> $stable(o_ip_demand))
        else $error("demand changed without sync");
    a_demand_write: assert property (wr_ok && hit_demand |=> demand_reg == $past(i_od_req.wdata))
        else $error("demand write lost");
    a_pos_offset: assert property (##1 o_cmd.pos == ($past(pos_off_en) ? 32'($past(i_set.pos)
        + $past(pos_off_reg)) : $past(i_set.pos)))
        else $error("position offset wrong");
    a_spd_offset: assert property (i_mode == MODE_CLK_DIR |=> o_cmd.spd == 32'($past(i_set.spd)
        + $past(spd_off_reg)))
        else $error("speed offset missing");
    a_trq_offset: assert property (i_mode == MODE_IP |=> o_cmd.trq == $past(i_set.trq))
        else $error("torque offset applied out of mode");
    a_trq_cst: assert property (i_mode == MODE_CST |=> o_cmd.trq == 16'($past(i_set.trq)
        + $past(trq_off_reg)))
        else $error("torque offset missing in cst");
    a_pos_unit_rsvd: assert property (o_pos_unit[15:0] == 16'h0000)
        else $error("position unit reserved bits set");
    a_vel_unit_rsvd: assert property (wr_ok && hit_vel_unit |=> o_vel_unit[7:0] == 8'h00
        && o_vel_unit[31:8] == $past(i_od_req.wdata[31:8]))
        else $error("velocity unit write wrong");
    // Cycle register lags the period by one edge, so compare against the old period
    a_cycle_ms: assert property (expo_reg == IP_EXPONENT_MS |=>
        o_ip_cycle_us == 32'({24'h000000, $past(period_reg)} * 32'h000003e8))
        else $error("cycle time wrong");
    a_count_ro: assert property (i_od_req.wr && (hit_rec_cnt || hit_per_cnt) |=> o_od_err && o_od_ack)
        else $error("count entry write not refused");
    // Every access is answered on the following edge
    a_ack_follows: assert property ((i_od_req.wr || i_od_req.rd) |=> o_od_ack)
        else $error("access not answered");
    // No answer and no refusal without an access
    a_ack_idle: assert property (!(i_od_req.wr || i_od_req.rd) |=> !o_od_ack && !o_od_err)
        else $error("answer without access");
    // Accepted writes are never flagged as refused
    a_write_ok: assert property (wr_ok |=> o_od_ack && !o_od_err)
        else $error("good write refused");
    // Position unit keeps code and exponent fields of a write
    a_pos_unit_write: assert property (wr_ok && hit_pos_unit |=>
        o_pos_unit[31:16] == $past(i_od_req.wdata[31:16]))
        else $error("position unit write wrong");
    // Read of the demand entry returns the written value
    a_demand_read: assert property (i_od_req.rd && !i_od_req.wr && hit_demand |=>
        o_od_rdata == $past(demand_reg))
        else $error("demand read wrong");
    // Read of the period entry returns the stored value
    a_period_read: assert property (i_od_req.rd && !i_od_req.wr && hit_period |=>
        o_od_rdata == {24'h000000, $past(period_reg)})
        else $error("period read wrong");
    // Position offset added in cyclic position mode
    a_pos_csp: assert property (i_mode == MODE_CSP |=>
        o_cmd.pos == 32'($past(i_set.pos) + $past(pos_off_reg)))
        else $error("position offset missing in csp");
    // Position set value passes untouched in every other mode
    a_pos_plain: assert property (i_mode != MODE_CSP |=> o_cmd.pos == $past(i_set.pos))
        else $error("position offset applied out of mode");
    // Speed offset also in cyclic velocity mode
    a_spd_csv: assert property (i_mode == MODE_CSV |=>
        o_cmd.spd == 32'($past(i_set.spd) + $past(spd_off_reg)))
        else $error("speed offset missing in csv");
    // Speed passes unchanged in torque and interpolated modes
    a_spd_plain: assert property (i_mode == MODE_CST || i_mode == MODE_IP |=>
        o_cmd.spd == $past(i_set.spd))
        else $error("speed offset applied out of mode");
    // Torque offset also active in cyclic position mode
    a_trq_csp: assert property (i_mode == MODE_CSP |=>
        o_cmd.trq == 16'($past(i_set.trq) + $past(trq_off_reg)))
        else $error("torque offset missing in csp");
    // Exponent write raises the flag unless it selects milliseconds
    a_exp_flag: assert property (wr_ok && hit_expo |=>
        o_ip_exp_bad == ($past(i_od_req.wdata[7:0]) != IP_EXPONENT_MS))
        else $error("exponent flag wrong");
    // Ten millisecond base scales the period by ten thousand
    a_cycle_ten_ms: assert property (expo_reg == -8'sd2 |=>
        o_ip_cycle_us == 32'({24'h000000, $past(period_reg)} * 32'h00002710))
        else $error("cycle time wrong at ten ms");

    // Main scenarios the bench is expected to reach
    c_sync_demand: cover property (wr_ok && hit_demand ##[1:4] i_sync);
    c_csp_offset:  cover property (i_mode == MODE_CSP && pos_off_reg != 32'h00000000);
    c_bad_access:  cover property (o_od_err);
    c_exp_change:  cover property (wr_ok && hit_expo ##1 o_ip_exp_bad);
    c_clk_dir_spd: cover property (i_mode == MODE_CLK_DIR && spd_off_reg != 32'h00000000);

endmodule // drive_unit_offset_interp_objects

`default_nettype wire

/* verif/drive_unit_offset_interp_objects_bench.sv */
`default_nettype none

module drive_unit_offset_interp_objects_bench
    import drive_objects_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk = 1'b0;   // 40 MHz clock
    logic        nrst    = 1'b0;   // Active low reset
    od_req_s     od_req;           // Request from master model
    logic        od_ack, od_err;   // Answer strobes
    logic [31:0] od_rdata;         // Read data
    logic        sync = 1'b0;      // Sync instant
    drive_mode_e mode = MODE_OTHER; // Operating mode
    setpoint_s   set  = '0;        // Set values in
    setpoint_s   cmd;              // Set values out
    logic signed [31:0] ip_demand;
    logic [31:0] pos_unit, vel_unit, ip_cycle_us;
    logic        ip_exp_bad;
    logic        ack, err;         // Last answer
    logic [31:0] rdata;
    int          err_count   = 0;
    int          check_count = 0;

    // Reset table: index, subindex, expected read value
    localparam logic [55:0] RST_TAB [10] = '{
        {16'h60a8, 8'h00, 32'hff410000}, {16'h60a9, 8'h00, 32'h00b44700},
        {16'h60b0, 8'h00, 32'h00000000}, {16'h60b1, 8'h00, 32'h00000000},
        {16'h60b2, 8'h00, 32'h00000000}, {16'h60c1, 8'h00, 32'h00000001},
        {16'h60c1, 8'h01, 32'h00000000}, {16'h60c2, 8'h00, 32'h00000002},
        {16'h60c2, 8'h01, 32'h00000001}, {16'h60c2, 8'h02, 32'h000000fd}};

    always #12.5 sys_clk = ~sys_clk;

    drive_unit_offset_interp_objects dut
    (
        .i_sys_clk(sys_clk), .i_nrst(nrst), .i_od_req(od_req), .o_od_ack(od_ack), .o_od_err(od_err),
        .o_od_rdata(od_rdata), .i_sync(sync), .i_mode(mode), .i_set(set), .o_cmd(cmd),
        .o_ip_demand(ip_demand), .o_pos_unit(pos_unit), .o_vel_unit(vel_unit),
        .o_ip_cycle_us(ip_cycle_us), .o_ip_exp_bad(ip_exp_bad)
    );

    od_master_model master
    (
        .i_sys_clk(sys_clk), .o_od_req(od_req), .i_od_ack(od_ack), .i_od_err(od_err), .i_od_rdata(od_rdata)
    );

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %s saw %h wanted %h", $time, what, seen, exp);
        end
    endtask

    // Dictionary access through the master model
    task automatic od(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd);
        master.access(wr, idx, sub, wd, ack, err, rdata);
    endtask

    // Reset values of every entry and of the unit and cycle time outputs
    task automatic test_reset_values();
        check(pos_unit, 32'hff410000, "pos unit out");
        check(vel_unit, 32'h00b44700, "vel unit out");
        check(ip_cycle_us, 32'd1000, "cycle time");
        for (int i = 0; i < 10; i++)
        begin
            od(1'b0, RST_TAB[i][55:40], RST_TAB[i][39:32], 32'h0);
            check(32'({ack, err}), 32'h00000002, "reset answer");
            check(rdata, RST_TAB[i][31:0], "reset read");
        end
    endtask

    // Reserved unit bits stay zero
    task automatic test_units();
        od(1'b1, IDX_POS_UNIT, SUB_COUNT, 32'h12345678);
        od(1'b0, IDX_POS_UNIT, SUB_COUNT, 32'h0);
        check(rdata, 32'h12340000, "pos unit read");
        check(pos_unit, 32'h12340000, "pos unit out");
        od(1'b1, IDX_VEL_UNIT, SUB_COUNT, 32'hfedcba98);
        od(1'b0, IDX_VEL_UNIT, SUB_COUNT, 32'h0);
        check(rdata, 32'hfedcba00, "vel unit read");
        check(vel_unit, 32'hfedcba00, "vel unit out");
    endtask

    // Offsets per mode, with wrap
    task automatic test_offsets();
        setpoint_s e;
        od(1'b1, IDX_POS_OFFSET, SUB_COUNT, 32'h00000010);
        od(1'b1, IDX_SPD_OFFSET, SUB_COUNT, 32'hfffffff0);
        od(1'b1, IDX_TRQ_OFFSET, SUB_COUNT, 32'hffff0002);
        od(1'b0, IDX_TRQ_OFFSET, SUB_COUNT, 32'h0);
        check(rdata, 32'h00000002, "trq offset read");
        @(posedge sys_clk);
        set <= '{32'sh7ffffff8, 32'sh00000100, 16'sh7fff};
        for (int m = 0; m < 6; m++)
        begin
            @(posedge sys_clk);
            mode <= drive_mode_e'(m);
            @(posedge sys_clk);
            #1;
            e.pos = (m == MODE_CSP) ? 32'h80000008 : 32'h7ffffff8;
            e.spd = (m inside {MODE_CSP, MODE_CSV, MODE_CLK_DIR}) ? 32'h000000f0 : 32'h00000100;
            e.trq = (m inside {MODE_CSP, MODE_CSV, MODE_CST, MODE_CLK_DIR}) ? 16'h8001 : 16'h7fff;
            check(cmd.pos, e.pos, "pos cmd");
            check(cmd.spd, e.spd, "spd cmd");
            check({16'h0000, cmd.trq}, {16'h0000, e.trq}, "trq cmd");
        end
    endtask

    // Demand taken only at sync; a write in the sync cycle waits
    task automatic test_demand();
        od(1'b1, IDX_IP_RECORD, SUB_FIRST, 32'h80000123);
        check(ip_demand, 32'h00000000, "demand before sync");
        fork
            od(1'b1, IDX_IP_RECORD, SUB_FIRST, 32'h00000456);
            begin
                @(posedge sys_clk);
                sync <= 1'b1;
                @(posedge sys_clk);
                sync <= 1'b0;
            end
        join
        check(ip_demand, 32'h80000123, "demand at sync");
        @(posedge sys_clk);
        sync <= 1'b1;
        @(posedge sys_clk);
        sync <= 1'b0;
        #1;
        check(ip_demand, 32'h00000456, "demand next sync");
    endtask

    // Cycle time, exponent flag and refused accesses
    task automatic test_period();
        od(1'b1, IDX_IP_PERIOD, SUB_FIRST, 32'h000000ff);
        repeat (2) @(posedge sys_clk);
        #1;
        check(ip_cycle_us, 32'd255000, "cycle ms");
        od(1'b1, IDX_IP_PERIOD, SUB_SECND, 32'h000000fe);
        repeat (2) @(posedge sys_clk);
        #1;
        check(ip_cycle_us, 32'd2550000, "cycle 10 ms");
        check(32'(ip_exp_bad), 32'h00000001, "exponent flag set");
        master.set_ms_base(ack, err, rdata);
        repeat (2) @(posedge sys_clk);
        #1;
        check(ip_cycle_us, 32'd255000, "cycle back");
        check(32'(ip_exp_bad), 32'h00000000, "exponent flag clear");
        od(1'b1, IDX_IP_RECORD, SUB_COUNT, 32'h00000009);
        check({ack, err}, 2'b11, "ro write");
        od(1'b0, IDX_IP_RECORD, SUB_COUNT, 32'h0);
        check(rdata, 32'h00000001, "ro kept");
        od(1'b0, 16'h6000, SUB_COUNT, 32'h0);
        check({ack, err}, 2'b11, "unknown read");
    endtask

    // Verdict and end of run
    task automatic tally_and_finish();
        if (err_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        #1;
        test_reset_values();
        test_units();
        test_offsets();
        test_demand();
        test_period();
        tally_and_finish();
    end

    // Watchdog well beyond the roughly 80 cycles the tests need
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        err_count++;
        tally_and_finish();
    end
endmodule // drive_unit_offset_interp_objects_bench

`default_nettype wire

/* verif/od_master_model.sv */
`default_nettype none

module od_master_model
    import drive_objects_pkg::*;
(
    // Clock
    input  wire logic        i_sys_clk,
    // Request towards the object dictionary
    output var od_req_s      o_od_req,
    // Registered answer
    input  wire logic        i_od_ack,
    input  wire logic        i_od_err,
    input  wire logic [31:0] i_od_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus: no strobe, address and data parked on junk
    initial o_od_req = '{1'b0, 1'b0, 16'hffff, 8'hff, 32'hdeadbeef};

    // One access: strobe for one edge, then pick up the answer a cycle later
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                          input logic [31:0] wd, output logic ack, output logic err, output logic [31:0] rd);
        @(posedge i_sys_clk);
        o_od_req <= '{wr, !wr, idx, sub, wd};
        @(posedge i_sys_clk);
        // Released lines carry the inverse so stale values are not trusted
        o_od_req <= '{1'b0, 1'b0, ~idx, ~sub, ~wd};
        #1;
        ack = i_od_ack;
        err = i_od_err;
        rd = i_od_rdata;
    endtask

    // Master task that programs the millisecond time base
    task automatic set_ms_base(output logic ack, output logic err, output logic [31:0] rd);
        access(1'b1, IDX_IP_PERIOD, SUB_SECND, {24'h000000, IP_EXPONENT_MS}, ack, err, rd);
    endtask
endmodule // od_master_model

`default_nettype wire
